// [dv/plfs_periph_model.sv]
// Behavioural model of the serial, timer and A/D peripherals facing the pin mux
`timescale 1ns/1ps
module plfs_periph_model (
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    input  wire logic [3:0] i_pattern,
    output logic            o_serial2_clock,
    output logic            o_adc_done,
    output logic            o_ccb,
    output logic            o_cca
);
    // Peripheral outputs are flops, so they move one edge after the bench asks
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            {o_cca, o_ccb, o_adc_done, o_serial2_clock} <= 4'h0;
        end else begin
            {o_cca, o_ccb, o_adc_done, o_serial2_clock} <= i_pattern;
        end
    end
endmodule

// [dv/port_l_low_pin_function_select_test.sv]
// Register and pin routing tests for the port L low pin function select block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module port_l_low_pin_function_select_test;
    import plfs_pkg::*;
    logic        clk = 0, srst = 1, stby = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [3:0]  pstrb = 4'h0, pat = 4'h0;
    logic        pready, pslverr, err, serial2_clock, adc, ccb, cca;
    logic [7:0]  pin_in = 8'h00, pin_out, pin_oe, gpio = 8'h00, dir = 8'h00, gpio_in;
    logic [1:0]  sel = 2'h0;
    // Many output pins share this bus, so it is a net, one driver per bit
    wire  [12:0] per;
    int          bad_count = 0, comparisons = 0;
    always #25 clk = ~clk;
    plfs_periph_model PEER (.i_clk(clk), .i_srst(srst), .i_pattern(pat), .o_serial2_clock(serial2_clock),
        .o_adc_done(adc), .o_ccb(ccb), .o_cca(cca));
    plfs_pin_mux DUT (.I_CLK(clk), .I_SRST(srst), .I_HW_STANDBY(stby), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .I_PSTRB(pstrb), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_PRDATA(prdata),
        .I_PIN_IN(pin_in), .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe), .I_GPIO_OUT(gpio),
        .I_PIN_DIR(dir), .O_GPIO_IN(gpio_in), .I_SERIAL2_CLOCK_OUT(serial2_clock),
        .O_SERIAL2_CLOCK_IN(per[12]), .I_ADC_CONVERSION_DONE_OUT(adc),
        .O_ADC_TRIGGER_IN_1(per[11]), .O_ADC_TRIGGER_IN_0(per[10]),
        .O_TIMER_EXT_CLOCK_B(per[9]), .I_TIMER11_CAPCOMP_B_OUT(ccb),
        .O_TIMER11_CAPCOMP_B_IN(per[8]), .I_TIMER11_CAPCOMP_A_OUT(cca),
        .O_TIMER11_CAPCOMP_A_IN(per[7]), .O_EXT_INTERRUPT_IN_7(per[6]),
        .O_EXT_INTERRUPT_IN_6(per[5]), .O_TIMER_EDGE_IN_10(per[4]), .I_HI_SCK_SEL(sel),
        .I_HI_SCK_TO_PIN(2'h3), .I_HI_SCK_FROM_PIN(2'h3), .O_HI_SCK_TO_PIN(per[3:2]),
        .O_HI_SCK_FROM_PIN(per[1:0]));
    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge clk);
        penable <= 1;
        // No cycle count is assumed; only the watchdog ends a wait for ready
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        apb(1, a, {16'h0000, d}, 4'hF);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [15:0] ex);
        apb(0, a, 32'h0000_0000, 4'h0);
        `CHK("read data", {16'h0000, ex}, rd)
        `CHK("slave error", 1'b0, err)
    endtask
    // Program both registers and the pins, then compare every routed output
    task automatic scen(input logic [15:0] f, iv, input logic [7:0] p, d, g,
                        input logic [3:0] pt, input logic [1:0] sl,
                        input logic [7:0] eoe, eout, input logic [12:0] eper);
        wr(PLFS_OFS_FUNC, f);
        wr(PLFS_OFS_INV, iv);
        pin_in <= p; dir <= d; gpio <= g; pat <= pt; sel <= sl;
        repeat (4) @(posedge clk);
        #1;
        `CHK("pin enable", eoe, pin_oe)
        `CHK("pin drive", eout, pin_out & pin_oe)
        `CHK("peripheral inputs", eper, per)
        `CHK("pin readback", p, gpio_in)
        rdchk(PLFS_OFS_FUNC, f & 16'h557D);
        rdchk(PLFS_OFS_INV, iv & 16'h0380);
        $display("routing test done for function %h", f);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Watchdog well above the roughly 140 cycles the tests take
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        results();
    end
    initial begin
        repeat (6) @(posedge clk);
        srst <= 0;
        rdchk(PLFS_OFS_FUNC, 16'h0000);
        rdchk(PLFS_OFS_INV, 16'h0000);
        wr(PLFS_OFS_FUNC, 16'hFFFF);
        rdchk(PLFS_OFS_FUNC, 16'h557D);
        wr(PLFS_OFS_INV, 16'hFFFF);
        rdchk(PLFS_OFS_INV, 16'h0380);
        wr(PLFS_OFS_FUNC, 16'h0000);
        apb(1, PLFS_OFS_FUNC, 32'h0000_FFFF, 4'h1);
        rdchk(PLFS_OFS_FUNC, 16'h007D);
        apb(1, 12'h008, 32'h0000_FFFF, 4'hF);
        `CHK("unmapped write error", 1'b1, err)
        apb(0, 12'h008, 32'h0000_0000, 4'h0);
        `CHK("unmapped read error", 1'b1, err)
        `CHK("unmapped read data", 32'h0000_0000, rd)
        $display("register test done");
        scen(16'h0000, 16'h0000, 8'hFF, 8'hA5, 8'h3C, 4'hF, 2'h0, 8'hA5, 8'h24, 13'h000F);
        scen(16'h5559, 16'h0380, 8'hFF, 8'hFF, 8'h00, 4'h7, 2'h1, 8'hC4, 8'h44, 13'h0F3A);
        scen(16'h0024, 16'h0380, 8'hFF, 8'hFF, 8'h80, 4'h8, 2'h1, 8'hFB, 8'h82, 13'h00CA);
        scen(16'h003C, 16'h0380, 8'hFF, 8'h06, 8'h06, 4'hF, 2'h1, 8'h06, 8'h06, 13'h000A);
        // Idle time stands in for sleep: contents must survive it
        repeat (20) @(posedge clk);
        rdchk(PLFS_OFS_FUNC, 16'h003C);
        rdchk(PLFS_OFS_INV, 16'h0380);
        @(posedge clk);
        stby <= 1;
        repeat (2) @(posedge clk);
        stby <= 0;
        rdchk(PLFS_OFS_FUNC, 16'h0000);
        rdchk(PLFS_OFS_INV, 16'h0000);
        $display("standby test done");
        results();
    end
endmodule

// [hw/plfs_pin_mux.sv]
// Port L low pin function select, serial clock inversion and APB registers
//
// Functional notes
// - Bit 14: pin 7 GPIO or serial2 clock
// - Bit 12: pin 6 GPIO or ADC done
// - Bit 10: pin 5 GPIO or ADC trigger 1
// - Bit 8: pin 4 GPIO or ADC trigger 0
// - Bit 6: pin 3 GPIO or timer clock B
// - Bits 5:4: pin 2 GPIO/capcomp B/interrupt 7
// - Bits 3:2: pin 1 GPIO/capcomp A/interrupt 6
// - Bit 0: pin 0 GPIO or timer edge 10
// - Reserved function bits read zero, ignore writes
// - Invert register writable at bits 9..7 only
// - Inversion acts only in serial clock function
// - Invert bit set flips the serial clock
// - Invert register clears on reset, hardware standby
// - Invert register held through software standby and sleep
// - Function register clears on reset, hardware standby
// - Direction bit sets output for bidirectional functions
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
module plfs_pin_mux
    import plfs_pkg::*;
(
    input  wire logic        I_CLK,
    input  wire logic        I_SRST,
    input  wire logic        I_HW_STANDBY,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    input  wire logic [3:0]  I_PSTRB,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    output logic [31:0]      O_PRDATA,
    input  wire logic [7:0]  I_PIN_IN,
    output logic [7:0]       O_PIN_OUT,
    output logic [7:0]       O_PIN_OE,
    input  wire logic [7:0]  I_GPIO_OUT,
    input  wire logic [7:0]  I_PIN_DIR,
    output logic [7:0]       O_GPIO_IN,
    input  wire logic        I_SERIAL2_CLOCK_OUT,
    output logic             O_SERIAL2_CLOCK_IN,
    input  wire logic        I_ADC_CONVERSION_DONE_OUT,
    output logic             O_ADC_TRIGGER_IN_1,
    output logic             O_ADC_TRIGGER_IN_0,
    output logic             O_TIMER_EXT_CLOCK_B,
    input  wire logic        I_TIMER11_CAPCOMP_B_OUT,
    output logic             O_TIMER11_CAPCOMP_B_IN,
    input  wire logic        I_TIMER11_CAPCOMP_A_OUT,
    output logic             O_TIMER11_CAPCOMP_A_IN,
    output logic             O_EXT_INTERRUPT_IN_7,
    output logic             O_EXT_INTERRUPT_IN_6,
    output logic             O_TIMER_EDGE_IN_10,
    input  wire logic [1:0]  I_HI_SCK_SEL,
    input  wire logic [1:0]  I_HI_SCK_TO_PIN,
    input  wire logic [1:0]  I_HI_SCK_FROM_PIN,
    output logic [1:0]       O_HI_SCK_TO_PIN,
    output logic [1:0]       O_HI_SCK_FROM_PIN
);

    logic [15:0] func_reg;
    logic [15:0] inv_reg;
    logic [31:0] prdata_reg;
    logic [7:0]  pin_out_next;
    logic [7:0]  pin_oe_next;
    logic        bus_write;
    logic        hit_func;
    logic        hit_inv;
    logic [1:0]  p2_sel;
    logic [1:0]  p1_sel;

    // Two-bit mode decode; code 11 falls back to GPIO
    function automatic logic [1:0] dual_decode(input logic [1:0] code);
        logic [1:0] sel;
        sel = 2'b00;
        case (code)
            PLFS_DUAL_TIMER: sel = 2'b01;
            PLFS_DUAL_IRQ:   sel = 2'b10;
            default:         sel = 2'b00;
        endcase
        return sel;
    endfunction

    // Byte-lane merge of a write into a 16-bit register with a write mask
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wdata,
                                            input logic [3:0]  strb,
                                            input logic [15:0] wmask);
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
        return (old & ~lanes) | (wdata[15:0] & lanes);
    endfunction

    // Address decode and APB handshake; zero wait states
    assign hit_func  = (I_PADDR == PLFS_OFS_FUNC);
    assign hit_inv   = (I_PADDR == PLFS_OFS_INV);
    assign O_PREADY  = I_PSEL & I_PENABLE;
    assign O_PSLVERR = I_PSEL & I_PENABLE & ~hit_func & ~hit_inv;
    assign bus_write = I_PSEL & I_PENABLE & I_PWRITE;
    assign O_PRDATA  = prdata_reg;

    // Read data is captured in the setup cycle so the access phase shows a flop
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            prdata_reg <= 32'h0000_0000;
        end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
            if (hit_func) begin
                prdata_reg <= {16'h0000, func_reg & PLFS_FUNC_WMASK};
            end else if (hit_inv) begin
                prdata_reg <= {16'h0000, inv_reg & PLFS_INV_WMASK};
            end else begin
                prdata_reg <= 32'h0000_0000;
            end
        end
    end

    // Function register: no clear in sleep or software standby
    always_ff @(posedge I_CLK) begin
        if (I_SRST || I_HW_STANDBY) begin
            func_reg <= PLFS_FUNC_RST;
        end else if (bus_write && hit_func) begin
            func_reg <= merge16(func_reg, I_PWDATA, I_PSTRB, PLFS_FUNC_WMASK);
        end
    end

    // Invert register: only bits 9..7 ever hold a one
    always_ff @(posedge I_CLK) begin
        if (I_SRST || I_HW_STANDBY) begin
            inv_reg <= PLFS_INV_RST;
        end else if (bus_write && hit_inv) begin
            inv_reg <= merge16(inv_reg, I_PWDATA, I_PSTRB, PLFS_INV_WMASK);
        end
    end

    assign p2_sel = dual_decode(func_reg[PLFS_POS_PIN2 +: 2]);
    assign p1_sel = dual_decode(func_reg[PLFS_POS_PIN1 +: 2]);

    // Pin drive select; GPIO direction bit steers every bidirectional function
    always_comb begin
        pin_out_next = I_GPIO_OUT;
        pin_oe_next  = I_PIN_DIR;
        if (func_reg[PLFS_POS_PIN7]) begin
            pin_out_next[7] = I_SERIAL2_CLOCK_OUT ^ inv_reg[PLFS_POS_INV7];
        end
        if (func_reg[PLFS_POS_PIN6]) begin
            pin_out_next[6] = I_ADC_CONVERSION_DONE_OUT;
            pin_oe_next[6]  = 1'b1;
        end
        if (func_reg[PLFS_POS_PIN5]) begin
            pin_oe_next[5] = 1'b0;
        end
        if (func_reg[PLFS_POS_PIN4]) begin
            pin_oe_next[4] = 1'b0;
        end
        if (func_reg[PLFS_POS_PIN3]) begin
            pin_oe_next[3] = 1'b0;
        end
        if (p2_sel[0]) begin
            pin_out_next[2] = I_TIMER11_CAPCOMP_B_OUT;
        end else if (p2_sel[1]) begin
            pin_oe_next[2] = 1'b0;
        end
        if (p1_sel[0]) begin
            pin_out_next[1] = I_TIMER11_CAPCOMP_A_OUT;
        end else if (p1_sel[1]) begin
            pin_oe_next[1] = 1'b0;
        end
        if (func_reg[PLFS_POS_PIN0]) begin
            pin_oe_next[0] = 1'b0;
        end
    end

    // Pin drive flops; one cycle of latency on every outbound path
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_PIN_OUT <= 8'h00;
            O_PIN_OE  <= 8'h00;
        end else begin
            O_PIN_OUT <= pin_out_next;
            O_PIN_OE  <= pin_oe_next;
        end
    end

    // Inbound routing; unselected peripheral inputs sit low so they see no edges
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_GPIO_IN              <= 8'h00;
            O_SERIAL2_CLOCK_IN     <= 1'b0;
            O_ADC_TRIGGER_IN_1     <= 1'b0;
            O_ADC_TRIGGER_IN_0     <= 1'b0;
            O_TIMER_EXT_CLOCK_B    <= 1'b0;
            O_TIMER11_CAPCOMP_B_IN <= 1'b0;
            O_TIMER11_CAPCOMP_A_IN <= 1'b0;
            O_EXT_INTERRUPT_IN_7   <= 1'b0;
            O_EXT_INTERRUPT_IN_6   <= 1'b0;
            O_TIMER_EDGE_IN_10     <= 1'b0;
        end else begin
            O_GPIO_IN              <= I_PIN_IN;
            O_SERIAL2_CLOCK_IN     <= func_reg[PLFS_POS_PIN7] &
                                      (I_PIN_IN[7] ^ inv_reg[PLFS_POS_INV7]);
            O_ADC_TRIGGER_IN_1     <= func_reg[PLFS_POS_PIN5] & I_PIN_IN[5];
            O_ADC_TRIGGER_IN_0     <= func_reg[PLFS_POS_PIN4] & I_PIN_IN[4];
            O_TIMER_EXT_CLOCK_B    <= func_reg[PLFS_POS_PIN3] & I_PIN_IN[3];
            O_TIMER11_CAPCOMP_B_IN <= p2_sel[0] & I_PIN_IN[2];
            O_TIMER11_CAPCOMP_A_IN <= p1_sel[0] & I_PIN_IN[1];
            O_EXT_INTERRUPT_IN_7   <= p2_sel[1] & I_PIN_IN[2];
            O_EXT_INTERRUPT_IN_6   <= p1_sel[1] & I_PIN_IN[1];
            O_TIMER_EDGE_IN_10     <= func_reg[PLFS_POS_PIN0] & I_PIN_IN[0];
        end
    end

    // Upper serial clock pins: their function select lives outside this block
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_HI_SCK_TO_PIN   <= 2'b00;
            O_HI_SCK_FROM_PIN <= 2'b00;
        end else begin
            O_HI_SCK_TO_PIN   <= I_HI_SCK_TO_PIN ^
                (I_HI_SCK_SEL & inv_reg[PLFS_POS_INV9:PLFS_POS_INV8]);
            O_HI_SCK_FROM_PIN <= I_HI_SCK_FROM_PIN ^
                (I_HI_SCK_SEL & inv_reg[PLFS_POS_INV9:PLFS_POS_INV8]);
        end
    end

    // Checks on pin routing, register access and hardware standby clear
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);

    AST_PIN7_SERIAL: assert property (
        func_reg[PLFS_POS_PIN7] && I_PIN_DIR[7] |=> O_PIN_OE[7] &&
        (O_PIN_OUT[7] == ($past(I_SERIAL2_CLOCK_OUT) ^ $past(inv_reg[PLFS_POS_INV7]))))
        else $error("Pin 7 serial clock drive wrong");

    AST_PIN6_ADC_DONE: assert property (
        func_reg[PLFS_POS_PIN6] |=> O_PIN_OE[6] &&
        (O_PIN_OUT[6] == $past(I_ADC_CONVERSION_DONE_OUT)))
        else $error("Pin 6 does not carry conversion done");

    AST_PIN5_TRIG: assert property (
        func_reg[PLFS_POS_PIN5] |=> !O_PIN_OE[5] &&
        (O_ADC_TRIGGER_IN_1 == $past(I_PIN_IN[5])))
        else $error("Pin 5 trigger routing wrong");

    AST_PIN4_TRIG_OFF: assert property (
        !func_reg[PLFS_POS_PIN4] |=> !O_ADC_TRIGGER_IN_0 &&
        (O_PIN_OE[4] == $past(I_PIN_DIR[4])))
        else $error("Pin 4 trigger active in GPIO mode");

    AST_PIN3_TCLK: assert property (
        func_reg[PLFS_POS_PIN3] ##1 func_reg[PLFS_POS_PIN3] |->
        O_TIMER_EXT_CLOCK_B == $past(I_PIN_IN[3]))
        else $error("Pin 3 timer clock routing wrong");

    AST_PIN2_IRQ: assert property (
        func_reg[PLFS_POS_PIN2 +: 2] == PLFS_DUAL_IRQ |=> !O_PIN_OE[2] &&
        !O_TIMER11_CAPCOMP_B_IN && (O_EXT_INTERRUPT_IN_7 == $past(I_PIN_IN[2])))
        else $error("Pin 2 interrupt routing wrong");

    AST_PIN1_CAPCOMP: assert property (
        func_reg[PLFS_POS_PIN1 +: 2] == PLFS_DUAL_TIMER |=>
        (O_PIN_OE[1] == $past(I_PIN_DIR[1])) && !O_EXT_INTERRUPT_IN_6 &&
        (O_PIN_OUT[1] == $past(I_TIMER11_CAPCOMP_A_OUT)))
        else $error("Pin 1 capture compare routing wrong");

    AST_PIN0_EDGE: assert property (
        func_reg[PLFS_POS_PIN0] |=> !O_PIN_OE[0] &&
        (O_TIMER_EDGE_IN_10 == $past(I_PIN_IN[0])))
        else $error("Pin 0 edge input routing wrong");

    AST_FUNC_RSVD_ZERO: assert property (
        I_PSEL && !I_PENABLE && !I_PWRITE && hit_func |=>
        (O_PRDATA & ~{16'h0000, PLFS_FUNC_WMASK}) == 32'h0000_0000)
        else $error("Reserved function bits read nonzero");

    AST_INV_RSVD_ZERO: assert property (
        (inv_reg & ~PLFS_INV_WMASK) == 16'h0000)
        else $error("Invert register holds a read-only bit");

    AST_PIN7_GPIO_NO_INV: assert property (
        !func_reg[PLFS_POS_PIN7] |=> (O_PIN_OUT[7] == $past(I_GPIO_OUT[7])) &&
        !O_SERIAL2_CLOCK_IN)
        else $error("Inversion leaked into GPIO pin 7");

    AST_STANDBY_CLEAR: assert property (
        I_HW_STANDBY |=> func_reg == PLFS_FUNC_RST && inv_reg == PLFS_INV_RST)
        else $error("Hardware standby did not clear registers");

    AST_INV_HOLD: assert property (
        !I_HW_STANDBY && !(bus_write && hit_inv) |=> $stable(inv_reg))
        else $error("Invert register changed without a write");

    AST_RSVD_CODE_GPIO: assert property (
        func_reg[PLFS_POS_PIN2 +: 2] == 2'h3 |=>
        (O_PIN_OE[2] == $past(I_PIN_DIR[2])) && !O_EXT_INTERRUPT_IN_7 &&
        (O_PIN_OUT[2] == $past(I_GPIO_OUT[2])))
        else $error("Reserved code did not fall back to GPIO");

    // Main scenarios reached
    COV_SERIAL_INVERTED: cover property (
        func_reg[PLFS_POS_PIN7] && inv_reg[PLFS_POS_INV7] && I_PIN_DIR[7]);
    COV_FUNC_WRITE: cover property (bus_write && hit_func);
    COV_UNMAPPED: cover property (O_PSLVERR);
    COV_PIN1_IRQ: cover property (func_reg[PLFS_POS_PIN1 +: 2] == PLFS_DUAL_IRQ);

endmodule

// [include/plfs_pkg.sv]
// Constants for the port L low pin function select block
package plfs_pkg;
    // Register byte offsets on the APB bus
    localparam logic [11:0] PLFS_OFS_FUNC    = 12'h000;
    localparam logic [11:0] PLFS_OFS_INV     = 12'h004;
    // Reset values
    localparam logic [15:0] PLFS_FUNC_RST    = 16'h0000;
    localparam logic [15:0] PLFS_INV_RST     = 16'h0000;
    // Writable bits; everything else reads zero
    localparam logic [15:0] PLFS_FUNC_WMASK  = 16'h557D;
    localparam logic [15:0] PLFS_INV_WMASK   = 16'h0380;
    // Field positions in the low function register
    localparam int          PLFS_POS_PIN7    = 14;
    localparam int          PLFS_POS_PIN6    = 12;
    localparam int          PLFS_POS_PIN5    = 10;
    localparam int          PLFS_POS_PIN4    = 8;
    localparam int          PLFS_POS_PIN3    = 6;
    localparam int          PLFS_POS_PIN2    = 4;
    localparam int          PLFS_POS_PIN1    = 2;
    localparam int          PLFS_POS_PIN0    = 0;
    // Field positions in the clock invert register
    localparam int          PLFS_POS_INV7    = 7;
    localparam int          PLFS_POS_INV8    = 8;
    localparam int          PLFS_POS_INV9    = 9;
    // Codes of the two-bit mode fields
    localparam logic [1:0]  PLFS_DUAL_GPIO   = 2'h0;
    localparam logic [1:0]  PLFS_DUAL_TIMER  = 2'h1;
    localparam logic [1:0]  PLFS_DUAL_IRQ    = 2'h2;
endpackage
